// *** hdl/hpg_pkg.sv ***
// Package for the high-port GPIO bank: offsets, reset values and carriers.
package hpg_pkg;

    timeunit 1ns;
    timeprecision 1ns;

    localparam int          HPG_ADDR_W        = 8;
    localparam int          HPG_DATA_W        = 8;
    localparam int          HPG_NUM_PORTS     = 4;
    localparam int          HPG_PIN_W         = 32;

    localparam logic [7:0]  HPG_OFS_PORT4     = 8'h84;
    localparam logic [7:0]  HPG_OFS_PORT5     = 8'h85;
    localparam logic [7:0]  HPG_OFS_PORT6     = 8'h86;
    localparam logic [7:0]  HPG_OFS_PORT7     = 8'h96;
    localparam logic [7:0]  HPG_OFS_MODE      = 8'hb5;
    localparam logic [7:0]  HPG_OFS_XBAR2     = 8'he3;

    localparam logic [7:0]  HPG_RST_LATCH     = 8'hff;
    localparam logic [7:0]  HPG_RST_MODE      = 8'h00;
    localparam logic [7:0]  HPG_RST_XBAR2     = 8'h00;

    localparam int          HPG_PUD_BIT       = 7;
    localparam int          HPG_EMLE_BIT      = 1;

    // Pin positions within the 32-bit pin vector: port4 at bits 7..0.
    localparam int          HPG_WR_PIN        = 7;
    localparam int          HPG_RD_PIN        = 6;
    localparam int          HPG_ALE_PIN       = 5;
    localparam int          HPG_P5_LSB        = 8;
    localparam int          HPG_P6_LSB        = 16;
    localparam int          HPG_P7_LSB        = 24;

    typedef struct packed {
        logic [HPG_ADDR_W-1:0] addr;
        logic [HPG_DATA_W-1:0] wdata;
        logic                  wr;
        logic                  rd;
        logic                  rmw;
    } hpg_bus_type;

    typedef struct packed {
        logic        active;
        logic        muxed;
        logic        read;
        logic        wr_n;
        logic        rd_n;
        logic        ale;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } hpg_external_memory_interface_type;

endpackage : hpg_pkg

// *** hdl/hpg_gpio_bank.sv ***
// High-port GPIO bank: latches, nibble drive modes, pull-ups, memory override.
//
// Behaviour
// - Open-drain latch 0 pulls low, 1 releases.
// - Each mode bit covers a four-pin nibble.
// - Mode bit 7 is port7 high nibble, 1=push-pull.
// - Pull-ups on by default, global disable bit.
// - Pull-up off while pin drives low.
// - Memory interface overrides latches during moves.
// - Memory reads release data pins; modes kept.
// - Latch writes appear on the pins.
// - Normal reads return synchronised pin levels.
// - Port4 pins 7..5 carry write, read, latch strobes.
// - Port5 carries upper address in non-multiplexed mode.
// - Port6 carries upper or lower address byte.
// - Port7 carries address/data or data byte.
// - Read-modify-write reads return latch contents.
module hpg_gpio_bank
    import hpg_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  clk_en,
    // Register bus.
    input  wire hpg_bus_type           bus,
    output logic [HPG_DATA_W-1:0]      rdata,
    // Memory interface request.
    input  wire hpg_external_memory_interface_type          external_memory_interface,
    // Pins.
    input  wire logic [HPG_PIN_W-1:0]  pin_in,
    output logic [HPG_PIN_W-1:0]       pin_out,
    output logic [HPG_PIN_W-1:0]       pin_oe_n,
    output logic [HPG_PIN_W-1:0]       pullup_en,
    output logic                       external_memory_interface_read_data,
    output logic [HPG_DATA_W-1:0]      external_memory_interface_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [HPG_NUM_PORTS-1:0][7:0] latch;
        logic [7:0]                    mode;
        logic [7:0]                    xbar2;
        logic [HPG_PIN_W-1:0]          sync1;
        logic [HPG_PIN_W-1:0]          sync2;
        logic [HPG_PIN_W-1:0]          sync3;
        logic [HPG_PIN_W-1:0]          level;
        logic [7:0]                    rdata;
        logic [HPG_PIN_W-1:0]          pin_out;
        logic [HPG_PIN_W-1:0]          pin_oe_n;
        logic [HPG_PIN_W-1:0]          pullup_en;
        logic                          external_memory_interface_read_data;
        logic [7:0]                    external_memory_interface_rdata;
    } hpg_state_type;

    hpg_state_type state_q;
    hpg_state_type state_d;

    logic [HPG_PIN_W-1:0]          latch_flat;
    logic [HPG_PIN_W-1:0]          push_pull;
    logic [HPG_PIN_W-1:0]          external_memory_interface_mask;
    logic [HPG_PIN_W-1:0]          external_memory_interface_val;
    logic [HPG_PIN_W-1:0]          drv_val;
    logic [HPG_PIN_W-1:0]          drv_oe_n;
    logic [HPG_PIN_W-1:0]          data_release;
    logic [HPG_PIN_W-1:0]          drives_low;
    logic [HPG_PIN_W-1:0]          pull_next;
    logic [HPG_PIN_W-1:0]          level_next;
    logic [HPG_NUM_PORTS-1:0][7:0] port_level;
    logic [HPG_NUM_PORTS-1:0][7:0] port_rback;
    logic                          external_memory_interface_addr_phase;
    logic                          external_memory_interface_release;
    logic                          pullup_off;

    assign latch_flat      = state_q.latch;
    assign pullup_off      = state_q.xbar2[HPG_PUD_BIT];
    // A multiplexed address phase still drives port7 during a read.
    assign external_memory_interface_addr_phase = external_memory_interface.muxed && external_memory_interface.ale;
    assign external_memory_interface_release    = external_memory_interface.active && external_memory_interface.read && !external_memory_interface_addr_phase;

    // Per-pin drive, pull-up and input qualification.
    genvar g;
    generate
        for (g = 0; g < HPG_PIN_W; g++) begin : g_pin
            // One mode bit per nibble; pin n uses mode bit n/4.
            assign push_pull[g]    = state_q.mode[g/4];
            // The interface value wins on the pins it owns.
            assign drv_val[g]      = external_memory_interface_mask[g] ? external_memory_interface_val[g]
                                                  : latch_flat[g];
            // Only the port7 data byte is freed by a read.
            assign data_release[g] = external_memory_interface_release && (g >= HPG_P7_LSB);
            // Push-pull drives both levels; open-drain drives only a zero.
            assign drv_oe_n[g]     = data_release[g]
                                     || (!push_pull[g] && drv_val[g]);
            assign drives_low[g]   = !drv_oe_n[g] && !drv_val[g];
            // A pin driving low never fights its own pull-up.
            assign pull_next[g]    = !pullup_off && !drives_low[g];
            // A new level counts once stages two and three agree.
            assign level_next[g]   = (state_q.sync2[g] == state_q.sync3[g])
                                     ? state_q.sync3[g] : state_q.level[g];
        end
    endgenerate

    // Per-port read-back values.
    genvar p;
    generate
        for (p = 0; p < HPG_NUM_PORTS; p++) begin : g_port
            assign port_level[p] = state_q.level[8*p +: 8];
            // A read-modify-write read sees the latch, not the pins.
            assign port_rback[p] = bus.rmw ? state_q.latch[p]
                                           : port_level[p];
        end
    endgenerate

    // Memory-interface pin map and values.
    always_comb begin
        external_memory_interface_mask = '0;
        external_memory_interface_val  = '0;
        if (external_memory_interface.active) begin
            external_memory_interface_mask[HPG_WR_PIN]  = 1'b1;
            external_memory_interface_mask[HPG_RD_PIN]  = 1'b1;
            external_memory_interface_mask[HPG_ALE_PIN] = 1'b1;
            external_memory_interface_val[HPG_WR_PIN]   = external_memory_interface.wr_n;
            external_memory_interface_val[HPG_RD_PIN]   = external_memory_interface.rd_n;
            external_memory_interface_val[HPG_ALE_PIN]  = external_memory_interface.ale;
            external_memory_interface_mask[HPG_P6_LSB +: 8] = 8'hff;
            external_memory_interface_mask[HPG_P7_LSB +: 8] = 8'hff;
            if (external_memory_interface.muxed) begin
                external_memory_interface_val[HPG_P6_LSB +: 8] = external_memory_interface.addr[15:8];
                external_memory_interface_val[HPG_P7_LSB +: 8] = external_memory_interface.ale ? external_memory_interface.addr[7:0]
                                                     : external_memory_interface.wdata;
            end else begin
                external_memory_interface_mask[HPG_P5_LSB +: 8] = 8'hff;
                external_memory_interface_val[HPG_P5_LSB +: 8]  = external_memory_interface.addr[15:8];
                external_memory_interface_val[HPG_P6_LSB +: 8]  = external_memory_interface.addr[7:0];
                external_memory_interface_val[HPG_P7_LSB +: 8]  = external_memory_interface.wdata;
            end
        end
    end

    always_comb begin
        state_d = state_q;
        // Three-flop pin synchroniser; level changes when stages 2 and 3 agree.
        state_d.sync1 = pin_in;
        state_d.sync2 = state_q.sync1;
        state_d.sync3 = state_q.sync2;
        state_d.level = level_next;
        state_d.rdata = 8'h00;
        if (bus.wr) begin
            unique case (bus.addr)
                HPG_OFS_PORT4: state_d.latch[0] = bus.wdata;
                HPG_OFS_PORT5: state_d.latch[1] = bus.wdata;
                HPG_OFS_PORT6: state_d.latch[2] = bus.wdata;
                HPG_OFS_PORT7: state_d.latch[3] = bus.wdata;
                HPG_OFS_MODE:  state_d.mode     = bus.wdata;
                HPG_OFS_XBAR2: state_d.xbar2    = bus.wdata;
                default: ;
            endcase
        end
        if (bus.rd) begin
            unique case (bus.addr)
                HPG_OFS_PORT4: state_d.rdata = port_rback[0];
                HPG_OFS_PORT5: state_d.rdata = port_rback[1];
                HPG_OFS_PORT6: state_d.rdata = port_rback[2];
                HPG_OFS_PORT7: state_d.rdata = port_rback[3];
                HPG_OFS_MODE:  state_d.rdata = state_q.mode;
                HPG_OFS_XBAR2: state_d.rdata = state_q.xbar2;
                default:       state_d.rdata = 8'h00;
            endcase
        end
        state_d.pin_out  = drv_val;
        state_d.pin_oe_n = drv_oe_n;
        state_d.pullup_en      = pull_next;
        state_d.external_memory_interface_read_data = external_memory_interface.active && external_memory_interface.read;
        state_d.external_memory_interface_rdata     = port_level[HPG_NUM_PORTS-1];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q.latch          <= {HPG_NUM_PORTS{HPG_RST_LATCH}};
            state_q.mode           <= HPG_RST_MODE;
            state_q.xbar2          <= HPG_RST_XBAR2;
            state_q.sync1          <= '1;
            state_q.sync2          <= '1;
            state_q.sync3          <= '1;
            state_q.level          <= '1;
            state_q.rdata          <= 8'h00;
            state_q.pin_out        <= '1;
            state_q.pin_oe_n       <= '1;
            state_q.pullup_en      <= '1;
            state_q.external_memory_interface_read_data <= 1'b0;
            state_q.external_memory_interface_rdata     <= 8'h00;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    assign rdata          = state_q.rdata;
    assign pin_out        = state_q.pin_out;
    assign pin_oe_n       = state_q.pin_oe_n;
    assign pullup_en      = state_q.pullup_en;
    assign external_memory_interface_read_data = state_q.external_memory_interface_read_data;
    assign external_memory_interface_rdata     = state_q.external_memory_interface_rdata;

endmodule : hpg_gpio_bank

// *** verif/hpg_pin_model.sv ***
// Pad model: resolves each pin from chip drive, far side and pull-up.
module hpg_pin_model (
    // Chip side.
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe_n,
    input  wire logic [31:0] pullup_en,
    // Far side drivers, used only on released pins.
    input  wire logic [31:0] ext_en,
    input  wire logic [31:0] ext_val,
    output logic      [31:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // A released pin with no pull-up and no far driver reads low.
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                  | (pin_oe_n & ~ext_en & pullup_en);
endmodule : hpg_pin_model

// *** verif/hpg_gpio_bank_assertions.sv ***
// Checker for pin drive, pull-ups and memory override of the bank.
module hpg_gpio_bank_assertions
    import hpg_pkg::*;
(
    input wire logic         clk,
    input wire logic         resetn,
    input wire logic         clk_en,
    input wire hpg_bus_type  bus,
    input wire hpg_external_memory_interface_type external_memory_interface,
    input wire logic [31:0]  pin_out,
    input wire logic [31:0]  pin_oe_n,
    input wire logic [31:0]  pullup_en
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    function automatic logic [31:0] nib(logic [7:0] m);
        for (int i = 0; i < 8; i++)
            nib[4*i+:4] = {4{m[i]}};
    endfunction : nib
    sequence mode_wr;
        bus.wr && clk_en && bus.addr == HPG_OFS_MODE
        ##1 clk_en && !external_memory_interface.active;
    endsequence
    sequence p7_wr;
        bus.wr && clk_en && bus.addr == HPG_OFS_PORT7
        ##1 clk_en && !external_memory_interface.active;
    endsequence
    reset_rel_a: assert property ($rose(resetn) |-> &pin_oe_n && &pin_out
        && &pullup_en) else $error("pins not idle after reset");
    no_fight_a: assert property ((~pin_oe_n & ~pin_out & pullup_en) == '0)
        else $error("pull-up on a pin driving low");
    mode_map_a: assert property (mode_wr |=>
        pin_oe_n == (~nib($past(bus.wdata, 2)) & pin_out))
        else $error("drive enables disagree with mode");
    latch_pin_a: assert property (p7_wr |=>
        pin_out[31:24] == $past(bus.wdata, 2)) else $error("latch not on pins");
    ext_flat_a: assert property (external_memory_interface.active && clk_en && !external_memory_interface.muxed
        && !external_memory_interface.read |=> pin_out[31:8] ==
        $past({external_memory_interface.wdata, external_memory_interface.addr[7:0], external_memory_interface.addr[15:8]}))
        else $error("non-multiplexed pins wrong");
    ext_mux_a: assert property (external_memory_interface.active && clk_en && external_memory_interface.muxed
        && external_memory_interface.ale |=> pin_out[31:16] ==
        $past({external_memory_interface.addr[7:0], external_memory_interface.addr[15:8]}))
        else $error("multiplexed address pins wrong");
    strobe_pins_a: assert property (external_memory_interface.active && clk_en |=>
        pin_out[7:5] == $past({external_memory_interface.wr_n, external_memory_interface.rd_n, external_memory_interface.ale}))
        else $error("strobe pins wrong");
    rd_release_a: assert property (external_memory_interface.active && clk_en && external_memory_interface.read
        && !external_memory_interface.ale |=> pin_oe_n[31:24] == 8'hff) else $error("data pins driven");
endmodule : hpg_gpio_bank_assertions
bind hpg_gpio_bank hpg_gpio_bank_assertions u_hpg_gpio_bank_assertions (
    .clk(clk), .resetn(resetn), .clk_en(clk_en), .bus(bus), .external_memory_interface(external_memory_interface),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en));

// *** verif/hpg_gpio_bank_tb.sv ***
// Self-checking bench for the high-port GPIO bank.
module hpg_gpio_bank_tb
    import hpg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clk         = 1'b0;
    logic         resetn      = 1'b0;
    logic         clk_en      = 1'b1;
    hpg_bus_type  bus         = '0;
    hpg_external_memory_interface_type external_memory_interface        = '0;
    logic [31:0]  ext_en      = '0;
    logic [31:0]  ext_val     = '0;
    logic [7:0]   rdata;
    logic [7:0]   external_memory_interface_rdata;
    logic [31:0]  pin_in;
    logic [31:0]  pin_out;
    logic [31:0]  pin_oe_n;
    logic [31:0]  pullup_en;
    logic         external_memory_interface_read_data;
    int           error_cnt   = 0;
    int           comparisons = 0;
    hpg_gpio_bank u_hpg_gpio_bank (.clk(clk), .resetn(resetn), .clk_en(clk_en),
        .bus(bus), .rdata(rdata), .external_memory_interface(external_memory_interface), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
        .external_memory_interface_read_data(external_memory_interface_read_data), .external_memory_interface_rdata(external_memory_interface_rdata));
    hpg_pin_model u_hpg_pin_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic cmp(string nm, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : cmp
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, rmw: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(string nm, logic [7:0] a, logic m, logic [7:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, rmw: m};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        cmp(nm, exp, rdata);
    endtask : rd
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    initial begin
        #1000000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        #1;
        cmp("oe_n rst", 32'hffffffff, pin_oe_n);
        cmp("pullup rst", 32'hffffffff, pullup_en);
        rd("p4 rmw", HPG_OFS_PORT4, 1'b1, 8'hff);
        rd("mode rst", HPG_OFS_MODE, 1'b0, 8'h00);
        rd("unmapped", 8'h00, 1'b0, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(HPG_OFS_MODE, 8'h01 << i);
            settle();
            cmp("mode oe_n", ~(32'hf << 4 * i), pin_oe_n);
        end
        wr(HPG_OFS_MODE, 8'h00);
        ext_en <= 32'h00ff0000;
        ext_val <= 32'h005a0000;
        repeat (5) @(posedge clk);
        rd("p6 pins", HPG_OFS_PORT6, 1'b0, 8'h5a);
        rd("p6 rmw", HPG_OFS_PORT6, 1'b1, 8'hff);
        wr(HPG_OFS_XBAR2, 8'h80);
        ext_en <= '0;
        settle();
        cmp("pullup off", 32'h0, pullup_en);
        wr(HPG_OFS_XBAR2, 8'h00);
        // A write while the clock enable is low must be dropped.
        clk_en <= 1'b0;
        wr(HPG_OFS_PORT4, 8'h00);
        clk_en <= 1'b1;
        rd("p4 frozen", HPG_OFS_PORT4, 1'b1, 8'hff);
        wr(HPG_OFS_PORT7, 8'h3c);
        wr(HPG_OFS_MODE, 8'h80);
        settle();
        cmp("p7 out", 32'h3c, pin_out[31:24]);
        cmp("p7 oe_n", 32'h0c, pin_oe_n[31:24]);
        cmp("p7 pullup", 32'h3c, pullup_en[31:24]);
        wr(HPG_OFS_MODE, 8'hff);
        external_memory_interface <= '{active: 1'b1, muxed: 1'b0, read: 1'b0, wr_n: 1'b0,
                  rd_n: 1'b1, ale: 1'b0, addr: 16'h1234, wdata: 8'ha5};
        settle();
        cmp("ext flat", 32'ha53412, pin_out[31:8]);
        cmp("ext strobes", 32'h2, pin_out[7:5]);
        @(posedge clk) external_memory_interface.read <= 1'b1;
        ext_en <= 32'hff000000;
        ext_val <= 32'hc3000000;
        settle();
        cmp("ext rd oe_n", 32'hff, pin_oe_n[31:24]);
        cmp("ext rd flag", 32'h1, external_memory_interface_read_data);
        settle();
        settle();
        cmp("ext rd data", 32'hc3, external_memory_interface_rdata);
        @(posedge clk) external_memory_interface.read <= 1'b0;
        ext_en <= '0;
        external_memory_interface.muxed <= 1'b1;
        external_memory_interface.ale <= 1'b1;
        settle();
        cmp("ext mux", 32'h3412, pin_out[31:16]);
        @(posedge clk) external_memory_interface.active <= 1'b0;
        settle();
        cmp("p7 back", 32'h3c, pin_out[31:24]);
        rd("p7 rmw", HPG_OFS_PORT7, 1'b1, 8'h3c);
        wrap_up();
    end
endmodule : hpg_gpio_bank_tb
